//--- design/cc_event_pkg.sv
// Constants and types shared by the event and status register files.
package cc_event_pkg;
   localparam logic [7:0] EVENT_ADDR = 8'h03;
   localparam logic [7:0] STATUS_ADDR = 8'h04;
   localparam logic [7:0] EVENT_RESET = 8'h00;
   localparam logic [7:0] STATUS_RESET = 8'h00;
   localparam logic [7:0] UNMAPPED_DATA = 8'h00;
   // Bits that latch and clear on read; bit 4 is reserved, bit 2 is live.
   localparam logic [7:0] LATCH_MASK = 8'heb;
   localparam int EV_RECOVER = 7;
   localparam int EV_OVERCUR = 6;
   localparam int EV_OVERVOLT = 5;
   localparam int EV_OTP = 3;
   localparam int EV_FAULT = 2;
   localparam int EV_DETACH = 1;
   localparam int EV_ATTACH = 0;
   localparam int ST_VBUS = 7;
   localparam int ST_CUR_HI = 6;
   localparam int ST_CUR_LO = 5;
   localparam int ST_PARTNER_HI = 4;
   localparam int ST_PARTNER_LO = 2;
   localparam int ST_ORIENT_HI = 1;
   localparam int ST_ORIENT_LO = 0;
   localparam logic [1:0] CUR_STANDBY = 2'h0;
   localparam logic [2:0] PARTNER_NONE = 3'h0;
   localparam logic [2:0] PARTNER_DEVICE = 3'h1;
   localparam logic [2:0] PARTNER_HOST = 3'h2;
   localparam logic [2:0] PARTNER_AUDIO = 3'h3;
   localparam logic [2:0] PARTNER_DEBUG = 3'h4;
   localparam logic [1:0] ORIENT_NONE = 2'h0;
   localparam logic [1:0] ORIENT_LINE_A = 2'h1;
   localparam logic [1:0] ORIENT_LINE_B = 2'h2;
   localparam logic [1:0] ORIENT_UNDET = 2'h3;
   typedef enum logic [2:0] {
      PORT_UNATTACHED,
      PORT_ATTACHED_SNK,
      PORT_ATTACHED_SRC,
      PORT_AUDIO_ACC,
      PORT_DEBUG_ACC
   } port_state_t;
   typedef enum logic {MIRROR_IDLE, MIRROR_BUSY} mirror_state_t;
endpackage

//--- design/bit_sync3.sv
// Three-stage synchroniser; output moves once stages two and three agree.
`timescale 1ns/1ps
module bit_sync3 (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic d,
   output logic q
);
   logic s1_q;
   logic s2_q;
   logic s3_q;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         s1_q <= 1'b0;
         s2_q <= 1'b0;
         s3_q <= 1'b0;
      end else begin
         s1_q <= d;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         q <= 1'b0;
      end else if (s2_q == s3_q) begin
         q <= s3_q;
      end
   end
endmodule // bit_sync3

//--- design/event_latch.sv
// Sticky flag bank where a set in the clearing cycle wins.
`timescale 1ns/1ps
module event_latch #(
   parameter int WIDTH = 8
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [WIDTH-1:0] set,
   input wire logic [WIDTH-1:0] clr,
   output logic [WIDTH-1:0] flags
);
   genvar i;
   generate
      for (i = 0; i < WIDTH; i++) begin : g_bit
         always_ff @(posedge clk) begin
            if (!rst_n) begin
               flags[i] <= 1'b0;
            end else if (set[i]) begin
               flags[i] <= 1'b1;
            end else if (clr[i]) begin
               flags[i] <= 1'b0;
            end
         end
      end
   endgenerate
endmodule // event_latch

//--- design/cc_event_status_regs.sv
// Event and connection status registers with read-clear and interrupt pin.
`timescale 1ns/1ps
module cc_event_status_regs
   import cc_event_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire port_state_t port_state,
   input wire logic sink_role,
   input wire logic vbus_present,
   input wire logic [1:0] cur_detect,
   input wire logic config_line_a,
   input wire logic config_line_b,
   input wire logic overvoltage_event,
   input wire logic overcurrent_event,
   input wire logic overtemp_event,
   input wire logic int_mask,
   output logic irq_n_pin_o,
   output logic irq_n_pin_oe,
   input wire logic link_clk,
   input wire logic link_rst_n,
   input wire logic [7:0] reg_addr,
   input wire logic reg_rd_start,
   input wire logic reg_rd_done,
   output logic [7:0] reg_rd_data
);
   // Core domain state.
   port_state_t state_q;
   logic [2:0] fault_lvl_q;
   logic [2:0] fault_now;
   logic [2:0] fault_rise;
   logic fault_live;
   logic was_attached;
   logic now_attached;
   logic [7:0] ev_set;
   logic [7:0] ev_clr;
   logic [7:0] ev_q;
   logic [7:0] ev_view;
   logic [7:0] status_d;
   logic [7:0] status_q;
   logic [2:0] partner_d;
   logic [1:0] orient_d;
   logic [1:0] cur_d;
   logic vbus_d;
   logic pending;

   // Core to link mirror handshake.
   mirror_state_t mirror_q;
   logic [7:0] tx_ev_q;
   logic [7:0] tx_st_q;
   logic tx_tgl_q;
   logic ack_sync;

   // Link to core clear handshake.
   logic clr_sync;
   logic clr_seen_q;
   logic clr_pulse;

   // Link domain state.
   logic req_sync;
   logic ack_tgl_q;
   logic [7:0] mir_ev_q;
   logic [7:0] mir_st_q;
   logic [7:0] rd_addr_q;
   logic [7:0] snap_mask_q;
   logic [7:0] clr_mask_q;
   logic clr_tgl_q;
   logic [7:0] rd_data_q;

   // ---------------- Core domain: event detection ----------------

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         state_q <= PORT_UNATTACHED;
      end else begin
         state_q <= port_state;
      end
   end

   assign fault_now = {overvoltage_event, overcurrent_event, overtemp_event};

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         fault_lvl_q <= '0;
      end else begin
         fault_lvl_q <= fault_now;
      end
   end

   // Each fault channel gets the same rising-edge detector.
   genvar f;
   generate
      for (f = 0; f < 3; f++) begin : g_fault
         assign fault_rise[f] = fault_now[f] & ~fault_lvl_q[f];
      end
   endgenerate

   assign fault_live = |fault_now;

   assign was_attached = (state_q != PORT_UNATTACHED);
   assign now_attached = (port_state != PORT_UNATTACHED);

   // Level conditions raise their flag on the rising edge only, so a fault that
   // persists does not refill the register right after a read clears it.
   always_comb begin
      ev_set = EVENT_RESET;
      ev_set[EV_OVERVOLT] = fault_rise[2];
      ev_set[EV_OVERCUR] = fault_rise[1];
      ev_set[EV_OTP] = fault_rise[0];
      ev_set[EV_RECOVER] = (|fault_lvl_q) & ~fault_live;
      ev_set[EV_DETACH] = was_attached & ~now_attached;
      ev_set[EV_ATTACH] = ~was_attached & now_attached;
   end

   assign clr_pulse = clr_sync ^ clr_seen_q;
   // The mask changes only on the next completed event read; the link side does not wait for its toggle to settle here.
   assign ev_clr = clr_pulse ? (clr_mask_q & LATCH_MASK) : EVENT_RESET;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         clr_seen_q <= 1'b0;
      end else begin
         clr_seen_q <= clr_sync;
      end
   end

   event_latch #(
      .WIDTH(8)
   ) u_events (
      .clk(clk),
      .rst_n(rst_n),
      .set(ev_set & LATCH_MASK),
      .clr(ev_clr),
      .flags(ev_q)
   );

   always_comb begin
      ev_view = ev_q & LATCH_MASK;
      ev_view[EV_FAULT] = fault_live;
   end

   // ---------------- Core domain: connection status ----------------

   always_comb begin
      unique case (port_state)
         PORT_UNATTACHED: partner_d = PARTNER_NONE;
         PORT_ATTACHED_SNK: partner_d = PARTNER_HOST;
         PORT_ATTACHED_SRC: partner_d = PARTNER_DEVICE;
         PORT_AUDIO_ACC: partner_d = PARTNER_AUDIO;
         PORT_DEBUG_ACC: partner_d = PARTNER_DEBUG;
         default: partner_d = PARTNER_NONE;
      endcase
   end

   always_comb begin
      if (port_state == PORT_UNATTACHED) begin
         orient_d = ORIENT_NONE;
      end else if (port_state == PORT_AUDIO_ACC || port_state == PORT_DEBUG_ACC) begin
         orient_d = ORIENT_UNDET;
      end else if (config_line_a && !config_line_b) begin
         orient_d = ORIENT_LINE_A;
      end else if (config_line_b && !config_line_a) begin
         orient_d = ORIENT_LINE_B;
      end else begin
         orient_d = ORIENT_UNDET;
      end
   end

   assign vbus_d = vbus_present &
      (sink_role || port_state == PORT_AUDIO_ACC || port_state == PORT_DEBUG_ACC);

   assign cur_d = (sink_role && port_state == PORT_ATTACHED_SNK) ? cur_detect : CUR_STANDBY;

   always_comb begin
      status_d = STATUS_RESET;
      status_d[ST_VBUS] = vbus_d;
      status_d[ST_CUR_HI:ST_CUR_LO] = cur_d;
      status_d[ST_PARTNER_HI:ST_PARTNER_LO] = partner_d;
      status_d[ST_ORIENT_HI:ST_ORIENT_LO] = orient_d;
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         status_q <= STATUS_RESET;
      end else begin
         status_q <= status_d;
      end
   end

   // ---------------- Core domain: interrupt pin ----------------

   assign pending = |(ev_q & LATCH_MASK);
   assign irq_n_pin_o = 1'b0;
   assign irq_n_pin_oe = pending & ~int_mask;

   // ---------------- Core domain: mirror transmitter ----------------

   // The link side only sees a copy; a copy is resent whenever the live
   // value differs from the last one handed over, at the cost of a short lag.
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         mirror_q <= MIRROR_IDLE;
         tx_ev_q <= EVENT_RESET;
         tx_st_q <= STATUS_RESET;
         tx_tgl_q <= 1'b0;
      end else begin
         unique case (mirror_q)
            MIRROR_IDLE: begin
               if ({ev_view, status_q} != {tx_ev_q, tx_st_q}) begin
                  tx_ev_q <= ev_view;
                  tx_st_q <= status_q;
                  tx_tgl_q <= ~tx_tgl_q;
                  mirror_q <= MIRROR_BUSY;
               end
            end
            MIRROR_BUSY: begin
               if (ack_sync == tx_tgl_q) begin
                  mirror_q <= MIRROR_IDLE;
               end
            end
         endcase
      end
   end

   // Both toggles come back from the link clock, so they pass three sync stages and an output flop here.
   bit_sync3 u_ack_sync (
      .clk(clk),
      .rst_n(rst_n),
      .d(ack_tgl_q),
      .q(ack_sync)
   );

   bit_sync3 u_clr_sync (
      .clk(clk),
      .rst_n(rst_n),
      .d(clr_tgl_q),
      .q(clr_sync)
   );

   // ---------------- Link domain: mirror receiver ----------------

   bit_sync3 u_req_sync (
      .clk(link_clk),
      .rst_n(link_rst_n),
      .d(tx_tgl_q),
      .q(req_sync)
   );

   // The core holds the words still until this acknowledge returns.
   always_ff @(posedge link_clk) begin
      if (!link_rst_n) begin
         ack_tgl_q <= 1'b0;
         mir_ev_q <= EVENT_RESET;
         mir_st_q <= STATUS_RESET;
      end else if (req_sync != ack_tgl_q) begin
         ack_tgl_q <= req_sync;
         mir_ev_q <= tx_ev_q;
         mir_st_q <= tx_st_q;
      end
   end

   // ---------------- Link domain: register read ----------------

   always_ff @(posedge link_clk) begin
      if (!link_rst_n) begin
         rd_addr_q <= UNMAPPED_DATA;
         rd_data_q <= UNMAPPED_DATA;
      end else if (reg_rd_start) begin
         rd_addr_q <= reg_addr;
         if (reg_addr == EVENT_ADDR) begin
            rd_data_q <= mir_ev_q;
         end else if (reg_addr == STATUS_ADDR) begin
            rd_data_q <= mir_st_q;
         end else begin
            rd_data_q <= UNMAPPED_DATA;
         end
      end
   end

   assign reg_rd_data = rd_data_q;

   always_ff @(posedge link_clk) begin
      if (!link_rst_n) begin
         snap_mask_q <= EVENT_RESET;
      end else if (reg_rd_start) begin
         snap_mask_q <= (reg_addr == EVENT_ADDR) ? (mir_ev_q & LATCH_MASK) : EVENT_RESET;
      end
   end

   // A bit that sets again before this clear lands merges with the one already read.
   // completed read clears
   always_ff @(posedge link_clk) begin
      if (!link_rst_n) begin
         clr_mask_q <= EVENT_RESET;
         clr_tgl_q <= 1'b0;
      end else if (reg_rd_done && rd_addr_q == EVENT_ADDR) begin
         clr_mask_q <= snap_mask_q;
         clr_tgl_q <= ~clr_tgl_q;
      end
   end
endmodule // cc_event_status_regs

//--- dv/cc_regs_props.sv
// Assertion checker for the event and status register block.
`timescale 1ns/1ps
module cc_regs_props
   import cc_event_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire port_state_t port_state,
   input wire logic overvoltage_event,
   input wire logic overcurrent_event,
   input wire logic overtemp_event,
   input wire logic int_mask,
   input wire logic irq_n_pin_o,
   input wire logic irq_n_pin_oe,
   input wire logic link_clk,
   input wire logic link_rst_n,
   input wire logic [7:0] reg_addr,
   input wire logic reg_rd_start,
   input wire logic [7:0] reg_rd_data
);
   // Four unmasked cycles leave room for the state register and the edge detector.
   sequence open4;
      !int_mask [*4];
   endsequence
   mask_quiet_a:
      assert property (@(posedge clk) disable iff (!rst_n) int_mask |-> !irq_n_pin_oe)
      else $error("interrupt pulled while masked");
   pin_data_a:
      assert property (@(posedge clk) disable iff (!rst_n) irq_n_pin_o == 1'b0)
      else $error("interrupt data level not low");
   overvolt_irq_a:
      assert property (@(posedge clk) disable iff (!rst_n)
         $rose(overvoltage_event) ##1 open4 |-> irq_n_pin_oe)
      else $error("no irq on over-voltage");
   overcur_irq_a:
      assert property (@(posedge clk) disable iff (!rst_n)
         $rose(overcurrent_event) ##1 open4 |-> irq_n_pin_oe)
      else $error("no irq on over-current");
   otp_irq_a:
      assert property (@(posedge clk) disable iff (!rst_n)
         $rose(overtemp_event) ##1 open4 |-> irq_n_pin_oe) else $error("no irq on otp");
   attach_irq_a:
      assert property (@(posedge clk) disable iff (!rst_n) port_state != PORT_UNATTACHED &&
         $past(port_state) == PORT_UNATTACHED ##1 open4 |-> irq_n_pin_oe)
      else $error("no irq on attach");
   detach_irq_a:
      assert property (@(posedge clk) disable iff (!rst_n) port_state == PORT_UNATTACHED &&
         $past(port_state) != PORT_UNATTACHED ##1 open4 |-> irq_n_pin_oe)
      else $error("no irq on detach");
   unmapped_zero_a:
      assert property (@(posedge link_clk) disable iff (!link_rst_n) reg_rd_start &&
         reg_addr != EVENT_ADDR && reg_addr != STATUS_ADDR |=> reg_rd_data == UNMAPPED_DATA)
      else $error("unmapped read not zero");
   reserved_bit_a:
      assert property (@(posedge link_clk) disable iff (!link_rst_n)
         reg_rd_start && reg_addr == EVENT_ADDR |=> reg_rd_data[4] == 1'b0)
      else $error("reserved event bit set");
   data_hold_a:
      assert property (@(posedge link_clk) disable iff (!link_rst_n)
         !reg_rd_start |=> $stable(reg_rd_data)) else $error("read data moved");
   cover property (@(posedge clk) disable iff (!rst_n) $rose(irq_n_pin_oe));
   cover property (@(posedge clk) disable iff (!rst_n) int_mask && $rose(port_state != 3'h0));
   cover property (@(posedge link_clk) disable iff (!link_rst_n) reg_rd_start && reg_addr == 8'h05);
endmodule // cc_regs_props

//--- dv/sys_master.sv
// System master model that reads the block's registers over the link clock.
`timescale 1ns/1ps
module sys_master (
   input wire logic link_clk,
   input wire logic irq_n,
   output logic [7:0] reg_addr,
   output logic reg_rd_start,
   output logic reg_rd_done,
   input wire logic [7:0] reg_rd_data,
   output logic got,
   output logic [7:0] got_data
);
   initial begin
      reg_addr = 8'h00;
      reg_rd_start = 1'b0;
      reg_rd_done = 1'b0;
      got = 1'b0;
      got_data = 8'h00;
   end
   // The address is inverted once released so a stale value is never trusted.
   task automatic rd(input logic [7:0] a);
      @(posedge link_clk);
      #1;
      reg_addr = a;
      reg_rd_start = 1'b1;
      @(posedge link_clk);
      #1;
      reg_rd_start = 1'b0;
      got_data = reg_rd_data;
      got = 1'b1;
      reg_rd_done = 1'b1;
      @(posedge link_clk);
      #1;
      reg_rd_done = 1'b0;
      got = 1'b0;
      reg_addr = ~a;
   endtask
   task automatic service();
      for (int i = 0; i < 50 && irq_n !== 1'b0; i++) @(posedge link_clk);
      // The read mirror trails the core by several cycles, so let it catch up.
      repeat (10) @(posedge link_clk);
      rd(8'h03);
      rd(8'h04);
   endtask
endmodule // sys_master

//--- dv/cc_event_status_regs_test.sv
// Self-checking bench for the event and status register block.
`timescale 1ns/1ps
module cc_event_status_regs_test
   import cc_event_pkg::*;
;
   logic clk = 1'b0;
   logic link_clk = 1'b0;
   logic rst_n = 1'b0;
   logic link_rst_n = 1'b0;
   port_state_t port_state = PORT_UNATTACHED;
   logic sink_role = 1'b0, vbus_present = 1'b0, config_line_a = 1'b0, config_line_b = 1'b0;
   logic overvoltage_event = 1'b0, overcurrent_event = 1'b0, overtemp_event = 1'b0;
   logic int_mask = 1'b0;
   logic [1:0] cur_detect = 2'h0;
   logic irq_n_pin_o, irq_n_pin_oe, reg_rd_start, reg_rd_done, got;
   logic [7:0] reg_addr, reg_rd_data, got_data;
   logic [7:0] exp_q[$];
   logic [31:0] seed = 32'h000027bf;
   logic [31:0] r;
   int failures = 0;
   int n_checks = 0;
   int cycles = 0;
   int fb[3] = '{EV_OVERVOLT, EV_OVERCUR, EV_OTP};
   // The pin is open drain with a pull-up, so a released pin reads high.
   wire logic irq_n = irq_n_pin_oe ? irq_n_pin_o : 1'b1;
   always #10 clk = ~clk;
   initial begin
      #3.7;
      forever #80 link_clk = ~link_clk;
   end
   cc_event_status_regs u_cc_event_status_regs (.clk, .rst_n, .port_state, .sink_role,
      .vbus_present, .cur_detect, .config_line_a, .config_line_b, .overvoltage_event,
      .overcurrent_event, .overtemp_event, .int_mask, .irq_n_pin_o, .irq_n_pin_oe, .link_clk,
      .link_rst_n, .reg_addr, .reg_rd_start, .reg_rd_done, .reg_rd_data);
   sys_master u_sys_master (.link_clk, .irq_n, .reg_addr, .reg_rd_start, .reg_rd_done,
      .reg_rd_data, .got, .got_data);
   task automatic check(input logic [7:0] seen, input logic [7:0] want);
      n_checks++;
      if (seen !== want) begin
         failures++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, want);
      end
   endtask
   task automatic give_verdict();
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   always @(posedge link_clk) begin
      if (got === 1'b1) begin
         check(got_data, exp_q.pop_front());
      end
   end
   always @(posedge clk) begin
      cycles++;
      if (cycles == 30000) begin
         failures++;
         give_verdict();
      end
   end
   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   function automatic logic [7:0] stat(input int s, input logic [31:0] v);
      logic [2:0] p;
      logic [1:0] o;
      p = (s == 1) ? 3'h2 : (s == 2) ? 3'h1 : 3'(s);
      o = (s > 2 || v[3] == v[4]) ? 2'h3 : v[3] ? 2'h1 : 2'h2;
      return {v[0] & (s != 2), (s == 1) ? v[2:1] : 2'h0, p, o};
   endfunction
   task automatic rd(input logic [7:0] a, input logic [7:0] want);
      exp_q.push_back(want);
      u_sys_master.rd(a);
   endtask
   task automatic step();
      @(posedge clk);
      #1;
   endtask
   // The read mirror lags the core by several link cycles.
   task automatic settle();
      repeat (10) @(posedge link_clk);
   endtask
   task automatic fault(input int k, input logic v);
      step();
      case (k)
         0: overvoltage_event = v;
         1: overcurrent_event = v;
         default: overtemp_event = v;
      endcase
   endtask
   initial begin
      repeat (10) @(posedge clk);
      #1;
      rst_n = 1'b1;
      repeat (4) @(posedge link_clk);
      #1;
      link_rst_n = 1'b1;
      settle();
      rd(8'h04, STATUS_RESET);
      rd(8'h05, UNMAPPED_DATA);
      check({7'h00, irq_n_pin_oe}, 8'h00);
      $display("test reset done");
      for (int k = 0; k < 3; k++) begin
         fault(k, 1'b1);
         settle();
         check({7'h00, irq_n_pin_oe}, 8'h01);
         rd(8'h03, 8'h04 | (8'h01 << fb[k]));
         settle();
         rd(8'h03, 8'h04);
         check({7'h00, irq_n_pin_oe}, 8'h00);
         fault(k, 1'b0);
         settle();
         rd(8'h03, 8'h80);
         settle();
      end
      $display("test faults done");
      for (int rep = 0; rep < 3; rep++) for (int s = 1; s < 5; s++) begin
         r = xs();
         step();
         port_state = port_state_t'(s);
         sink_role = (s == 1);
         vbus_present = r[0];
         cur_detect = r[2:1];
         config_line_a = r[3];
         config_line_b = r[4];
         exp_q.push_back(8'h01);
         exp_q.push_back(stat(s, r));
         u_sys_master.service();
         step();
         port_state = PORT_UNATTACHED;
         sink_role = 1'b0;
         vbus_present = 1'b0;
         exp_q.push_back(8'h02);
         exp_q.push_back(8'h00);
         u_sys_master.service();
         settle();
      end
      $display("test attach done");
      step();
      int_mask = 1'b1;
      port_state = PORT_ATTACHED_SRC;
      settle();
      check({7'h00, irq_n_pin_oe}, 8'h00);
      step();
      int_mask = 1'b0;
      step();
      check({7'h00, irq_n_pin_oe}, 8'h01);
      check({7'h00, irq_n}, 8'h00);
      // An over-voltage raised as the read starts is not in its snapshot and must stay.
      fault(0, 1'b1);
      rd(8'h03, 8'h01);
      settle();
      rd(8'h03, 8'h24);
      settle();
      check({7'h00, irq_n_pin_oe}, 8'h00);
      $display("test mask done");
      give_verdict();
   end
endmodule // cc_event_status_regs_test
bind cc_event_status_regs cc_regs_props u_props (.clk, .rst_n, .port_state, .overvoltage_event,
   .overcurrent_event, .overtemp_event, .int_mask, .irq_n_pin_o, .irq_n_pin_oe, .link_clk,
   .link_rst_n, .reg_addr, .reg_rd_start, .reg_rd_data);
